/* inc/lsd_map.vh */
// Constants for the legacy region and system-management RAM decode block.
// Assumes an 8-bit configuration port and one routing request per clock.
// How it works
// - Addresses below 80000h always route to main memory.
// - 80000h-9FFFFh goes to memory unless the low hole input forwards it downstream.
// - Host video window cycles ignore attributes; route away unless SYSTEM_MANAGEMENT_MODE-visible.
// - Video window picks graphics port or downstream path from bridge VGA control.
// - Hub and graphics initiators are refused the video window when it is SYSTEM_MANAGEMENT_MODE space.
// - C0000h-DFFFFh is eight 16 KB segments with own read/write attributes.
// - E0000h-EFFFFh is four 16 KB segments with own read/write attributes.
// - F0000h-FFFFFh is one segment with one attribute pair.
// - Fixed hole enable sends host 15-16 MB cycles downstream; clear means no hole.
// - Hub cycles inside an enabled hole are ignored; the hole is never remapped.
// - Open, close and lock do nothing unless global enable is set.
// - Open with lock clear makes SYSTEM_MANAGEMENT_MODE DRAM visible outside SYSTEM_MANAGEMENT_MODE decode.
// - Close blocks data but not code references to compatible SYSTEM_MANAGEMENT_MODE DRAM.
// - Lock clears open, freezes lock-listed fields; only reset clears lock.
// - Lock is set by a plain configuration write.
// - Global enable makes 128 KB DRAM at A0000h reachable in SYSTEM_MANAGEMENT_MODE decode.
// - Global enable becomes read-only once lock is set.
// - Base segment reads fixed 010 and ignores writes.
// - SYSTEM_MANAGEMENT_MODE DRAM is not remapped; blocked host accesses go to graphics port or downstream per VGA control.
// - Segment read/write enable picks main memory when set, downstream when clear, for host cycles only.
`ifndef LSD_MAP_VH
`define LSD_MAP_VH

`define LSD_OFS_ATTR0 8'h90
`define LSD_OFS_ATTR6 8'h96
`define LSD_OFS_FHC 8'h97
`define LSD_OFS_SMC 8'h9D
`define LSD_OFS_ESMC 8'h9E

`define LSD_FHC_RESET 8'h00
`define LSD_SMC_RESET 8'h02
`define LSD_ESMC_RESET 8'h38
`define LSD_FHC_MASK 8'h80
`define LSD_ATTR_MASK 8'h33
`define LSD_ATTR0_MASK 8'h30

`define LSD_FHC_HEN 7
`define LSD_SMC_OPEN 6
`define LSD_SMC_CLOSE 5
`define LSD_SMC_LOCK 4
`define LSD_SMC_GEN 3
`define LSD_BASE_SEG 3'h2
`define LSD_ESMC_HIGH 7
`define LSD_ESMC_FIXED 3'h7

`define LSD_LOW_END 32'h0007FFFF
`define LSD_DOS_END 32'h0009FFFF
`define LSD_VGA_END 32'h000BFFFF
`define LSD_EXP_END 32'h000EFFFF
`define LSD_FW_END 32'h000FFFFF
`define LSD_HOLE_LO 32'h00F00000
`define LSD_HOLE_HI 32'h00FFFFFF
`define LSD_EXP_BASE 32'h000C0000

`define LSD_RG_LOW 3'h0
`define LSD_RG_DOS 3'h1
`define LSD_RG_VGA 3'h2
`define LSD_RG_SEG 3'h3
`define LSD_RG_HOLE 3'h4
`define LSD_RG_OTHER 3'h5
`define LSD_FW_SEG 4'hC

`define LSD_DST_MEM 2'h0
`define LSD_DST_DOWN 2'h1
`define LSD_DST_GFX 2'h2
`define LSD_DST_NONE 2'h3

`define LSD_SRC_HOST 2'h0
`define LSD_SRC_HUB 2'h1
`define LSD_SRC_GFX 2'h2

`endif

/* logic/lsd_region_dec.v */
// Address classifier for the legacy region and the fixed hole.
// Purely combinational; the caller registers whatever it derives.
`timescale 1ns/1ps
`include "lsd_map.vh"
module lsd_region_dec (
    input wire [31:0] addr_i, // Access address
    output reg [2:0] region_o, // Region class
    output reg [3:0] seg_o // Attribute segment, 0-11 from C0000h, 12 top
);
    reg [31:0] rel;
    always @* begin
        rel = addr_i - `LSD_EXP_BASE;
        seg_o = 4'h0;
        if (addr_i <= `LSD_LOW_END) begin
            region_o = `LSD_RG_LOW;
        end else if (addr_i <= `LSD_DOS_END) begin
            region_o = `LSD_RG_DOS;
        end else if (addr_i <= `LSD_VGA_END) begin
            region_o = `LSD_RG_VGA;
        end else if (addr_i <= `LSD_EXP_END) begin
            region_o = `LSD_RG_SEG;
            seg_o = rel[17:14];
        end else if (addr_i <= `LSD_FW_END) begin
            region_o = `LSD_RG_SEG;
            seg_o = `LSD_FW_SEG;
        end else if (addr_i >= `LSD_HOLE_LO && addr_i <= `LSD_HOLE_HI) begin
            region_o = `LSD_RG_HOLE;
        end else begin
            region_o = `LSD_RG_OTHER;
        end
    end
endmodule // lsd_region_dec

/* logic/lsd_attr_regs.v */
// Seven segment attribute registers with per-segment read/write enable lookup.
// Written through the shared configuration port; reserved bits stay zero.
`timescale 1ns/1ps
`include "lsd_map.vh"
module lsd_attr_regs #(
    parameter NREG = 7 // Attribute registers
) (
    input wire ref_clk_i, // Clock
    input wire reset_i, // Synchronous reset
    input wire cfg_wr_i, // Configuration write strobe
    input wire [7:0] cfg_addr_i, // Configuration offset
    input wire [7:0] cfg_wdata_i, // Write data
    input wire [3:0] seg_i, // Segment to look up
    output wire seg_re_o, // Read enable of segment
    output wire seg_we_o, // Write enable of segment
    output wire [7:0] rd_data_o // Register at cfg_addr_i
);
    reg [7:0] am_q [0:NREG-1];
    wire [7:0] idx = cfg_addr_i - `LSD_OFS_ATTR0;
    wire hit = cfg_addr_i >= `LSD_OFS_ATTR0 && cfg_addr_i <= `LSD_OFS_ATTR6;
    integer i;

    // Segment n from C0000h lives in register 1+n/2; the top area in the upper nibble of 0
    function [3:0] seg_nib;
        input [3:0] s;
        input [7:0] r;
        begin
            seg_nib = (s == `LSD_FW_SEG || s[0]) ? r[7:4] : r[3:0];
        end
    endfunction

    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            for (i = 0; i < NREG; i = i + 1) begin
                am_q[i] <= 8'h00;
            end
        end else if (cfg_wr_i && hit) begin
            am_q[idx[2:0]] <= cfg_wdata_i &
                ((idx == 8'h00) ? `LSD_ATTR0_MASK : `LSD_ATTR_MASK);
        end
    end

    // Register goes in as an argument so an attribute write re-evaluates the lookup
    wire [2:0] sel = (seg_i == `LSD_FW_SEG) ? 3'h0 : seg_i[3:1] + 3'h1;
    wire [3:0] nib = seg_nib(seg_i, am_q[sel]);
    assign seg_re_o = nib[0];
    assign seg_we_o = nib[1];
    assign rd_data_o = hit ? am_q[idx[2:0]] : 8'h00;
endmodule // lsd_attr_regs

/* logic/lsd_top.v */
// Legacy region and system-management RAM decode: control registers and routing.
// Assumes configuration strobes and access requests are synchronous to ref_clk_i,
// one of each at most per cycle; routing answers one cycle after the request.
`timescale 1ns/1ps
`include "lsd_map.vh"
module lsd_top (
    input wire ref_clk_i, // 200 MHz clock
    input wire reset_i, // Full reset, synchronous, active high
    input wire cfg_wr_i, // Configuration write strobe
    input wire cfg_rd_i, // Configuration read strobe
    input wire [7:0] cfg_addr_i, // Configuration offset
    input wire [7:0] cfg_wdata_i, // Configuration write data
    output reg [7:0] cfg_rdata_o, // Read data, valid with cfg_rvalid_o
    output reg cfg_rvalid_o, // Read data valid pulse
    input wire acc_valid_i, // Access request valid
    input wire [31:0] acc_addr_i, // Access address
    input wire acc_write_i, // 1 write, 0 read
    input wire [1:0] acc_src_i, // Initiator: host, hub, graphics
    input wire acc_smm_i, // Host cycle carries SYSTEM_MANAGEMENT_MODE decode
    input wire acc_code_i, // Host cycle is a code fetch
    input wire vga_to_gfx_i, // Bridge legacy VGA control selects graphics port
    input wire dos_hole_en_i, // Declares 80000h-9FFFFh a memory hole
    output reg rt_valid_o, // Routing answer valid pulse
    output reg [1:0] rt_dest_o, // Destination: mem, downstream, graphics, none
    output reg smm_lock_o, // Effective lock state
    output reg fixed_hole_enable_o // Fixed hole enabled
);
    reg fhc_hen_q;
    reg smm_open_q;
    reg smm_close_q;
    reg smm_lock_q;
    reg smm_global_enable_q;
    reg high_smm_space_enable_q;
    reg [1:0] top_segment_size_q;
    reg top_segment_enable_q;
    reg [7:0] rdata_d;
    reg [1:0] dest_d;
    reg smm_vis;
    wire [2:0] region;
    wire [3:0] seg;
    wire seg_re;
    wire seg_we;
    wire [7:0] attr_rd;
    wire is_host = acc_src_i == `LSD_SRC_HOST;
    wire vga_route = vga_to_gfx_i ? 1'b1 : 1'b0;
    // Open and close only act while the global enable is set
    wire open_act = smm_open_q & smm_global_enable_q & ~smm_lock_q;
    wire close_act = smm_close_q & smm_global_enable_q;
    wire smc_wr = cfg_wr_i && cfg_addr_i == `LSD_OFS_SMC;
    wire esmc_wr = cfg_wr_i && cfg_addr_i == `LSD_OFS_ESMC;
    wire lock_set = cfg_wdata_i[`LSD_SMC_LOCK] &
        (cfg_wdata_i[`LSD_SMC_GEN] | smm_global_enable_q);

    lsd_region_dec u_dec (
        .addr_i(acc_addr_i),
        .region_o(region),
        .seg_o(seg)
    );

    lsd_attr_regs #(
        .NREG(7)
    ) u_attr (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .cfg_wr_i(cfg_wr_i),
        .cfg_addr_i(cfg_addr_i),
        .cfg_wdata_i(cfg_wdata_i),
        .seg_i(seg),
        .seg_re_o(seg_re),
        .seg_we_o(seg_we),
        .rd_data_o(attr_rd)
    );

    // Fixed hole control; reserved bits are not stored
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            fhc_hen_q <= 1'b0;
        end else if (cfg_wr_i && cfg_addr_i == `LSD_OFS_FHC) begin
            fhc_hen_q <= cfg_wdata_i[`LSD_FHC_HEN];
        end
    end

    // SYSTEM_MANAGEMENT_MODE control. Lock is sticky until reset and freezes everything but close.
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            smm_open_q <= 1'b0;
            smm_close_q <= 1'b0;
            smm_lock_q <= 1'b0;
            smm_global_enable_q <= 1'b0;
        end else if (smc_wr) begin
            smm_close_q <= cfg_wdata_i[`LSD_SMC_CLOSE];
            if (!smm_lock_q) begin
                smm_global_enable_q <= cfg_wdata_i[`LSD_SMC_GEN];
                smm_lock_q <= lock_set;
                // Setting lock forces open off in the same write
                smm_open_q <= cfg_wdata_i[`LSD_SMC_OPEN] & ~lock_set;
            end
        end
    end

    // Extended SYSTEM_MANAGEMENT_MODE fields that lock freezes; sizing itself is decoded elsewhere
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            high_smm_space_enable_q <= 1'b0;
            top_segment_size_q <= 2'h0;
            top_segment_enable_q <= 1'b0;
        end else if (esmc_wr && !smm_lock_q) begin
            high_smm_space_enable_q <= cfg_wdata_i[`LSD_ESMC_HIGH];
            top_segment_size_q <= cfg_wdata_i[2:1];
            top_segment_enable_q <= cfg_wdata_i[0];
        end
    end

    // Readback; unmapped offsets read zero
    always @* begin
        rdata_d = attr_rd;
        case (cfg_addr_i)
            `LSD_OFS_FHC: begin
                rdata_d = {fhc_hen_q, 7'h00};
            end
            `LSD_OFS_SMC: begin
                rdata_d = {1'b0, smm_open_q, smm_close_q, smm_lock_q,
                    smm_global_enable_q, `LSD_BASE_SEG};
            end
            `LSD_OFS_ESMC: begin
                rdata_d = {high_smm_space_enable_q, 1'b0, `LSD_ESMC_FIXED,
                    top_segment_size_q, top_segment_enable_q};
            end
            default: begin
                rdata_d = attr_rd;
            end
        endcase
    end

    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            cfg_rdata_o <= 8'h00;
            cfg_rvalid_o <= 1'b0;
        end else begin
            cfg_rvalid_o <= cfg_rd_i;
            cfg_rdata_o <= cfg_rd_i ? rdata_d : 8'h00;
        end
    end

    // Routing decision
    always @* begin
        // SYSTEM_MANAGEMENT_MODE DRAM is only made visible, never remapped
        smm_vis = smm_global_enable_q &
            ((acc_smm_i & ~(close_act & ~acc_code_i)) | open_act);
        dest_d = `LSD_DST_MEM;
        case (region)
            `LSD_RG_LOW: begin
                dest_d = `LSD_DST_MEM;
            end
            `LSD_RG_DOS: begin
                dest_d = dos_hole_en_i ? `LSD_DST_DOWN : `LSD_DST_MEM;
            end
            `LSD_RG_VGA: begin
                if (is_host && smm_vis) begin
                    dest_d = `LSD_DST_MEM;
                end else if (!is_host && smm_global_enable_q) begin
                    dest_d = `LSD_DST_NONE;
                end else begin
                    // Attribute bits play no part here
                    dest_d = vga_route ? `LSD_DST_GFX : `LSD_DST_DOWN;
                end
            end
            `LSD_RG_SEG: begin
                if (!is_host) begin
                    dest_d = `LSD_DST_MEM;
                end else if (acc_write_i) begin
                    dest_d = seg_we ? `LSD_DST_MEM : `LSD_DST_DOWN;
                end else begin
                    dest_d = seg_re ? `LSD_DST_MEM : `LSD_DST_DOWN;
                end
            end
            `LSD_RG_HOLE: begin
                if (!fhc_hen_q) begin
                    dest_d = `LSD_DST_MEM;
                end else if (is_host) begin
                    dest_d = `LSD_DST_DOWN;
                end else begin
                    // Hole is not remapped, so hub cycles have no target at all
                    dest_d = `LSD_DST_NONE;
                end
            end
            default: begin
                dest_d = `LSD_DST_MEM;
            end
        endcase
    end

    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            rt_valid_o <= 1'b0;
            rt_dest_o <= `LSD_DST_MEM;
            smm_lock_o <= 1'b0;
            fixed_hole_enable_o <= 1'b0;
        end else begin
            rt_valid_o <= acc_valid_i;
            rt_dest_o <= acc_valid_i ? dest_d : `LSD_DST_MEM;
            smm_lock_o <= smm_lock_q;
            fixed_hole_enable_o <= fhc_hen_q;
        end
    end
endmodule // lsd_top

/* verif/lsd_top_monitor.sv */
// Concurrent checks on the routing and configuration ports of lsd_top.
// Assumes one clock domain and the synchronous active-high reset of the design.
`timescale 1ns/1ps
`include "lsd_map.vh"
module lsd_top_monitor (
    input wire ref_clk_i, // Clock
    input wire reset_i, // Reset
    input wire cfg_rd_i, // Read strobe
    input wire cfg_rvalid_o, // Read valid
    input wire acc_valid_i, // Request
    input wire [31:0] acc_addr_i, // Address
    input wire [1:0] acc_src_i, // Initiator
    input wire vga_to_gfx_i, // VGA select
    input wire dos_hole_en_i, // Low hole
    input wire rt_valid_o, // Answer valid
    input wire [1:0] rt_dest_o, // Destination
    input wire smm_lock_o // Lock
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    wire host = acc_src_i == `LSD_SRC_HOST;
    wire in_dos = acc_addr_i > `LSD_LOW_END && acc_addr_i <= `LSD_DOS_END;
    wire in_vga = acc_addr_i > `LSD_DOS_END && acc_addr_i <= `LSD_VGA_END;
    wire in_att = acc_addr_i > `LSD_VGA_END && acc_addr_i <= `LSD_FW_END;
    wire in_hole = acc_addr_i >= `LSD_HOLE_LO && acc_addr_i <= `LSD_HOLE_HI;
    sequence s_req_low;
        acc_valid_i && acc_addr_i <= `LSD_LOW_END;
    endsequence
    sequence s_to_mem;
        rt_valid_o && rt_dest_o == `LSD_DST_MEM;
    endsequence
    chk_low_mem: assert property (s_req_low |=> s_to_mem)
        else $error("low area access not sent to memory");
    chk_dos_mem: assert property (acc_valid_i && in_dos && !dos_hole_en_i |=> s_to_mem)
        else $error("area below video window left memory without hole");
    chk_vga_route: assert property (acc_valid_i && in_vga && !vga_to_gfx_i |=>
        rt_valid_o && rt_dest_o != `LSD_DST_GFX) else $error("video window sent to graphics");
    chk_vga_guard: assert property (acc_valid_i && in_vga && !host |=>
        rt_valid_o && rt_dest_o != `LSD_DST_MEM) else $error("non-host reached video DRAM");
    chk_attr_nonhost: assert property (acc_valid_i && in_att && !host |=> s_to_mem)
        else $error("non-host attribute segment access not sent to memory");
    chk_hub_hole: assert property (acc_valid_i && in_hole && !host |=>
        rt_valid_o && rt_dest_o != `LSD_DST_DOWN) else $error("hub cycle forwarded in hole");
    chk_lock_held: assert property (smm_lock_o |=> smm_lock_o)
        else $error("lock cleared without reset");
    chk_rd_answer: assert property (cfg_rd_i |=> cfg_rvalid_o)
        else $error("read strobe got no answer");
endmodule // lsd_top_monitor

bind lsd_top lsd_top_monitor i_lsd_top_monitor (.ref_clk_i, .reset_i, .cfg_rd_i,
    .cfg_rvalid_o, .acc_valid_i, .acc_addr_i, .acc_src_i, .vga_to_gfx_i, .dos_hole_en_i,
    .rt_valid_o, .rt_dest_o, .smm_lock_o);

/* verif/lsd_initiator.sv */
// Access initiator model: host, hub or graphics port issuing one request per go pulse.
// Assumes the bench drives go_i and req_i just after a rising edge.
`timescale 1ns/1ps
module lsd_initiator (
    input wire ref_clk_i, // Clock
    input wire go_i, // Issue one request
    input wire [36:0] req_i, // Source, address, write, smm, code
    output logic acc_valid_o, // Request valid
    output logic [1:0] acc_src_o, // Initiator
    output logic [31:0] acc_addr_o, // Address
    output logic acc_write_o, // Write
    output logic acc_smm_o, // SYSTEM_MANAGEMENT_MODE decode
    output logic acc_code_o // Code fetch
);
    initial begin
        {acc_valid_o, acc_src_o, acc_addr_o, acc_write_o, acc_smm_o, acc_code_o} = 38'h0;
    end
    // Idle address, smm and code qualifiers toggle so that stale values cannot pass for a request; source and write hold
    always @(posedge ref_clk_i) begin
        acc_valid_o <= go_i;
        if (go_i) begin
            {acc_src_o, acc_addr_o, acc_write_o, acc_smm_o, acc_code_o} <= req_i;
        end else begin
            acc_addr_o <= ~acc_addr_o;
            acc_smm_o <= ~acc_smm_o;
            acc_code_o <= ~acc_code_o;
        end
    end
endmodule // lsd_initiator

/* verif/lsd_top_bench.sv */
// Self-checking bench for lsd_top: routing table, control registers and reset.
// Assumes the initiator model in front of the access port.
`timescale 1ns/1ps
module lsd_top_bench;
    typedef struct {bit ph; logic [1:0] s; logic [31:0] a; logic w, sm, cd, vg, ds;
        logic [1:0] e;} lsd_row_t;
    logic ref_clk_i = 1'b0, reset_i = 1'b1, cfg_wr_i = 1'b0, cfg_rd_i = 1'b0, go = 1'b0;
    logic vga_to_gfx_i = 1'b0, dos_hole_en_i = 1'b0;
    logic [7:0] cfg_addr_i = 8'h00, cfg_wdata_i = 8'h00;
    logic [36:0] req = 37'h0;
    wire [7:0] cfg_rdata_o;
    wire cfg_rvalid_o, acc_valid_i, acc_write_i, acc_smm_i, acc_code_i;
    wire rt_valid_o, smm_lock_o, fixed_hole_enable_o;
    wire [31:0] acc_addr_i;
    wire [1:0] acc_src_i, rt_dest_o;
    int miscompares = 0, n_tests = 0, cycles = 0;
    lsd_row_t rows[] = '{
        '{0, 0, 32'h00000000, 0, 0, 0, 0, 0, 0}, '{0, 1, 32'h0007FFFF, 1, 0, 0, 0, 1, 0},
        '{0, 0, 32'h00080000, 0, 0, 0, 0, 1, 1}, '{0, 2, 32'h0009FFFF, 0, 0, 0, 0, 0, 0},
        '{0, 0, 32'h000A0000, 0, 0, 0, 0, 0, 1}, '{0, 0, 32'h000BFFFF, 1, 1, 0, 1, 0, 2},
        '{0, 1, 32'h000A0000, 0, 0, 0, 1, 0, 2}, '{0, 0, 32'h000C0000, 0, 0, 0, 0, 0, 1},
        '{0, 0, 32'h000FFFFF, 1, 0, 0, 0, 0, 1}, '{0, 1, 32'h000D0000, 1, 0, 0, 0, 0, 0},
        '{0, 0, 32'h00F00000, 0, 0, 0, 0, 0, 0}, '{0, 1, 32'h00FFFFFF, 0, 0, 0, 0, 0, 0},
        '{1, 0, 32'h000C0000, 0, 0, 0, 0, 0, 0}, '{1, 0, 32'h000C3FFF, 1, 0, 0, 0, 0, 1},
        '{1, 0, 32'h000C4000, 1, 0, 0, 0, 0, 0}, '{1, 0, 32'h000C7FFF, 0, 0, 0, 0, 0, 1},
        '{1, 0, 32'h000E8000, 1, 0, 0, 0, 0, 0}, '{1, 0, 32'h000EBFFF, 0, 0, 0, 0, 0, 1},
        '{1, 0, 32'h000EC000, 0, 0, 0, 0, 0, 0}, '{1, 0, 32'h000F0000, 0, 0, 0, 0, 0, 0},
        '{1, 0, 32'h000FFFFF, 1, 0, 0, 0, 0, 1}, '{1, 0, 32'h00F00000, 0, 0, 0, 0, 0, 1},
        '{1, 1, 32'h00FFFFFF, 0, 0, 0, 0, 0, 3}, '{1, 2, 32'h00F80000, 0, 0, 0, 0, 0, 3},
        '{1, 0, 32'h00EFFFFF, 0, 0, 0, 0, 0, 0}, '{1, 0, 32'h01000000, 1, 0, 0, 0, 0, 0}};
    always #2.5 ref_clk_i = ~ref_clk_i;
    lsd_top i_lsd_top (.ref_clk_i, .reset_i, .cfg_wr_i, .cfg_rd_i, .cfg_addr_i, .cfg_wdata_i,
        .cfg_rdata_o, .cfg_rvalid_o, .acc_valid_i, .acc_addr_i, .acc_write_i, .acc_src_i,
        .acc_smm_i, .acc_code_i, .vga_to_gfx_i, .dos_hole_en_i, .rt_valid_o, .rt_dest_o,
        .smm_lock_o, .fixed_hole_enable_o);
    lsd_initiator i_lsd_initiator (.ref_clk_i, .go_i(go), .req_i(req), .acc_valid_o(acc_valid_i),
        .acc_src_o(acc_src_i), .acc_addr_o(acc_addr_i), .acc_write_o(acc_write_i),
        .acc_smm_o(acc_smm_i), .acc_code_o(acc_code_i));
    task complete_run;
        begin
            $display("%0d checks, %0d mismatches", n_tests, miscompares);
            if (miscompares == 0 && n_tests > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            complete_run;
        end
    end
    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        begin
            n_tests++;
            if (g !== e) begin
                miscompares++;
                $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task cfg_w(input logic [7:0] a, input logic [7:0] d);
        begin
            @(posedge ref_clk_i);
            cfg_addr_i <= a;
            cfg_wdata_i <= d;
            cfg_wr_i <= 1'b1;
            @(posedge ref_clk_i);
            cfg_wr_i <= 1'b0;
        end
    endtask
    task cfg_r(input logic [7:0] a, input logic [7:0] e);
        begin
            @(posedge ref_clk_i);
            cfg_addr_i <= a;
            cfg_rd_i <= 1'b1;
            @(posedge ref_clk_i);
            cfg_rd_i <= 1'b0;
            @(negedge ref_clk_i);
            chk("read valid", 8'h01, {7'h0, cfg_rvalid_o});
            chk("read data", e, cfg_rdata_o);
        end
    endtask
    task acc(input lsd_row_t r);
        int n;
        begin
            @(posedge ref_clk_i);
            req <= {r.s, r.a, r.w, r.sm, r.cd};
            vga_to_gfx_i <= r.vg;
            dos_hole_en_i <= r.ds;
            go <= 1'b1;
            @(posedge ref_clk_i);
            go <= 1'b0;
            n = 0;
            @(negedge ref_clk_i);
            while (rt_valid_o !== 1'b1 && n < 8) begin
                @(negedge ref_clk_i);
                n++;
            end
            chk("route valid", 8'h01, {7'h0, rt_valid_o});
            chk("route", {6'h0, r.e}, {6'h0, rt_dest_o});
        end
    endtask
    task ax(input logic [1:0] s, input logic [31:0] a, input logic sm, cd, input logic [1:0] e);
        lsd_row_t r;
        begin
            r = '{0, s, a, 0, sm, cd, 0, 0, e};
            acc(r);
        end
    endtask
    initial begin
        repeat (2) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        cfg_r(8'h97, 8'h00);
        cfg_r(8'h9D, 8'h02);
        cfg_r(8'h9E, 8'h38);
        cfg_r(8'h80, 8'h00);
        for (int ph = 0; ph < 2; ph++) begin
            if (ph == 1) begin
                cfg_w(8'h91, 8'h21);
                cfg_w(8'h96, 8'h12);
                cfg_w(8'h90, 8'h10);
                cfg_w(8'h97, 8'hFF);
                cfg_r(8'h97, 8'h80);
                chk("hole enable", 8'h01, {7'h0, fixed_hole_enable_o});
            end
            foreach (rows[i]) if (rows[i].ph == ph) acc(rows[i]);
            $display("routing table phase %0d done", ph);
        end
        cfg_w(8'h9D, 8'h10);
        cfg_w(8'h9D, 8'h40);
        ax(0, 32'h000A0000, 0, 0, 1);
        chk("lock", 8'h00, {7'h0, smm_lock_o});
        cfg_w(8'h9D, 8'h88);
        cfg_r(8'h9D, 8'h0A);
        cfg_w(8'h9D, 8'h48);
        ax(0, 32'h000A0000, 0, 0, 0);
        ax(1, 32'h000A0000, 0, 0, 3);
        cfg_w(8'h9D, 8'h28);
        ax(0, 32'h000B0000, 1, 0, 1);
        ax(0, 32'h000B0000, 1, 1, 0);
        cfg_w(8'h9D, 8'h08);
        cfg_w(8'h9E, 8'h83);
        cfg_r(8'h9E, 8'hBB);
        ax(0, 32'h000A0000, 1, 0, 0);
        ax(0, 32'h000A0000, 0, 0, 1);
        cfg_w(8'h9D, 8'h18);
        cfg_r(8'h9D, 8'h1A);
        chk("lock", 8'h01, {7'h0, smm_lock_o});
        cfg_w(8'h9D, 8'h47);
        cfg_r(8'h9D, 8'h1A);
        cfg_w(8'h9E, 8'h00);
        cfg_r(8'h9E, 8'hBB);
        ax(0, 32'h000A0000, 0, 0, 1);
        ax(0, 32'h000A0000, 1, 0, 0);
        $display("smm control done");
        @(posedge ref_clk_i);
        reset_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        cfg_r(8'h9D, 8'h02);
        chk("lock", 8'h00, {7'h0, smm_lock_o});
        cfg_r(8'h91, 8'h00);
        cfg_r(8'h9E, 8'h38);
        chk("hole enable", 8'h00, {7'h0, fixed_hole_enable_o});
        $display("mid-run reset done");
        complete_run;
    end
endmodule // lsd_top_bench
